/* cssf_pkg.sv */
`default_nettype none
package cssf_pkg;

  // port count and register layout
  localparam int          NPORT      = 4;
  localparam int          IDX_W      = 8;
  localparam int          ADDR_W     = 10;
  // printed register offsets are indices; byte address is index * 4
  localparam logic [7:0]  PORT_A_SERIAL_STATUS_IDX = 8'hC3;
  localparam logic [7:0]  PORT_B_SERIAL_STATUS_IDX = 8'hD3;
  localparam logic [7:0]  PORT_C_SERIAL_STATUS_IDX = 8'hE3;
  localparam logic [7:0]  PORT_D_SERIAL_STATUS_IDX = 8'hF3;
  localparam logic [3:0][7:0] STAT_IDX = {PORT_D_SERIAL_STATUS_IDX,
                                          PORT_C_SERIAL_STATUS_IDX,
                                          PORT_B_SERIAL_STATUS_IDX,
                                          PORT_A_SERIAL_STATUS_IDX};
  // data registers: write fills the transmit buffer, read drains receive
  localparam logic [3:0][7:0] DATA_IDX = {8'hF0, 8'hE0, 8'hD0, 8'hC0};
  localparam logic [7:0]  IRQ_STAT_IDX = 8'h80;
  localparam logic [7:0]  IRQ_MASK_IDX = 8'h81;

  // status bit positions
  localparam int          RX_FULL_BIT = 7;
  localparam int          OVR_BIT     = 5;
  localparam int          TX_FULL_BIT = 3;
  localparam int          BUSY_BIT    = 2;

  // bits in one serial byte, in link clock cycles
  localparam logic [3:0]  BYTE_BITS   = 4'h8;

  // reset values
  localparam logic [7:0]  MASK_RST    = 8'h00;

  // axi4-lite response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : cssf_pkg
`default_nettype wire

/* cssf_serial_status.sv */
// Overview of operation
// - status bit 7 is set while the receive buffer holds an unread byte
// - receive interrupt request is held while the receive buffer is full
// - status bits 6 and 4 always read as zero in clocked mode
// - overrun bit 5 sets on receive overrun, clears on receive buffer read
// - status bit 3 shows a byte waiting in the transmit buffer
// - transmit interrupt request rises when a byte moves into the shifter
// - writing the transmit buffer clears a pending transmit interrupt
// - any status register write clears transmit interrupt, value ignored
// - status bit 2 is set while the transmitter shifts a byte
// - status bits 1:0 always read as zero in clocked mode
`default_nettype none
module cssf_serial_status
  import cssf_pkg::*;
#(
  parameter int NP = NPORT                   // number of serial ports
) (
  input  wire  logic              ref_clk,   // 40 MHz block clock
  input  wire  logic              rst,       // synchronous reset, high
  input  wire  logic              ce,        // clock enable, freezes state
  input  wire  logic [ADDR_W-1:0] awaddr,    // write address
  input  wire  logic              awvalid,   // write address valid
  output logic                    awready,   // write address ready
  input  wire  logic [31:0]       wdata,     // write data
  input  wire  logic [3:0]        wstrb,     // write byte strobes
  input  wire  logic              wvalid,    // write data valid
  output logic                    wready,    // write data ready
  output logic [1:0]              bresp,     // write response
  output logic                    bvalid,    // write response valid
  input  wire  logic              bready,    // write response ready
  input  wire  logic [ADDR_W-1:0] araddr,    // read address
  input  wire  logic              arvalid,   // read address valid
  output logic                    arready,   // read address ready
  output logic [31:0]             rdata,     // read data
  output logic [1:0]              rresp,     // read response
  output logic                    rvalid,    // read data valid
  input  wire  logic              rready,    // read data ready
  input  wire  logic [NP-1:0]     sclk,      // link clock per port
  input  wire  logic [NP-1:0]     sdi,       // serial data in per port
  output logic [NP-1:0]           sdo,       // serial data out per port
  output logic [NP-1:0]           rx_irq,    // receive request, level
  output logic [NP-1:0]           tx_irq,    // transmit request, level
  output logic                    irq        // masked sticky event irq
);

  // all state of the block
  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 aw_have;
    logic                 w_have;
    logic [IDX_W-1:0]     waddr;
    logic [7:0]           wbyte;
    logic                 wlane0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [NP-1:0]        sclk_s1;
    logic [NP-1:0]        sclk_s2;
    logic [NP-1:0]        sclk_s3;
    logic [NP-1:0]        sdi_s1;
    logic [NP-1:0]        sdi_s2;
    logic [NP-1:0][7:0]   rxbuf;
    logic [NP-1:0][7:0]   rx_sh;
    logic [NP-1:0][3:0]   rx_cnt;
    logic [NP-1:0]        rx_full;
    logic [NP-1:0]        ovr;
    logic [NP-1:0][7:0]   txbuf;
    logic [NP-1:0][7:0]   tx_sh;
    logic [NP-1:0][3:0]   tx_cnt;
    logic [NP-1:0]        tx_full;
    logic [NP-1:0]        busy;
    logic [NP-1:0]        tx_irq;
    logic [NP-1:0]        sdo;
    logic [2*NP-1:0]      sticky;
    logic [2*NP-1:0]      mask;
    logic                 irq;
  } cssf_state_s;

  cssf_state_s q_q;
  cssf_state_s q_d;

  logic [NP-1:0]    ev_wr_data;   // transmit buffer written
  logic [NP-1:0]    ev_wr_stat;   // status register written
  logic [NP-1:0]    ev_rd_data;   // receive buffer read
  logic [NP-1:0]    ev_load;      // byte moved into shifter
  logic [NP-1:0]    ev_done;      // last bit shifted out
  logic [NP-1:0]    ev_rx;        // byte assembled by receiver
  logic [NP-1:0]    rise;         // link clock rising edge
  logic [NP-1:0]    fall;         // link clock falling edge
  logic [NP-1:0][7:0] stat;       // status byte view per port
  logic             wr_go;        // write performed this cycle
  logic             rd_go;        // read accepted this cycle
  logic [IDX_W-1:0] ridx;         // read register index
  logic             hit_w;        // write address mapped
  logic             hit_r;        // read address mapped
  logic [7:0]       rbyte;        // read byte
  logic [7:0]       rx_new;       // byte completing in receiver

  // next-state logic
  always_comb begin
    q_d        = q_q;
    ev_wr_data = '0;
    ev_wr_stat = '0;
    ev_rd_data = '0;
    ev_load    = '0;
    ev_done    = '0;
    ev_rx      = '0;
    rise       = '0;
    fall       = '0;
    stat       = '0;
    rx_new     = '0;
    rbyte      = '0;
    hit_w      = 1'b0;
    hit_r      = 1'b0;
    ridx       = araddr[IDX_W+1:2];
    wr_go      = q_q.aw_have && q_q.w_have && !q_q.bvalid;
    rd_go      = arvalid && q_q.arready;

    // two-flop synchronisers, third stage for edge finding
    q_d.sclk_s1 = sclk;
    q_d.sclk_s2 = q_q.sclk_s1;
    q_d.sclk_s3 = q_q.sclk_s2;
    q_d.sdi_s1  = sdi;
    q_d.sdi_s2  = q_q.sdi_s1;

    // axi write channels, taken in either order
    if (awvalid && q_q.awready) begin
      q_d.waddr   = awaddr[IDX_W+1:2];
      q_d.aw_have = 1'b1;
      q_d.awready = 1'b0;
    end
    if (wvalid && q_q.wready) begin
      q_d.wbyte   = wdata[7:0];
      q_d.wlane0  = wstrb[0];
      q_d.w_have  = 1'b1;
      q_d.wready  = 1'b0;
    end

    // per-port register decode and status view
    for (int i = 0; i < NP; i++) begin
      stat[i][RX_FULL_BIT] = q_q.rx_full[i];
      stat[i][OVR_BIT]     = q_q.ovr[i];
      stat[i][TX_FULL_BIT] = q_q.tx_full[i];
      stat[i][BUSY_BIT]    = q_q.busy[i];
      // bits 6, 4 and 1:0 stay zero from the default above
      if (wr_go && q_q.waddr == DATA_IDX[i]) begin
        hit_w         = 1'b1;
        ev_wr_data[i] = q_q.wlane0;
      end
      if (wr_go && q_q.waddr == STAT_IDX[i]) begin
        hit_w         = 1'b1;
        ev_wr_stat[i] = 1'b1;                     // any value, no strobe
      end
      if (ridx == DATA_IDX[i]) begin
        hit_r         = 1'b1;
        rbyte         = q_q.rxbuf[i];
        ev_rd_data[i] = rd_go;
      end
      if (ridx == STAT_IDX[i]) begin
        hit_r         = 1'b1;
        rbyte         = stat[i];
      end
    end
    if (wr_go && q_q.waddr == IRQ_STAT_IDX) begin
      hit_w = 1'b1;
    end
    if (wr_go && q_q.waddr == IRQ_MASK_IDX) begin
      hit_w = 1'b1;
      if (q_q.wlane0) begin
        q_d.mask = q_q.wbyte;
      end
    end
    if (ridx == IRQ_STAT_IDX) begin
      hit_r = 1'b1;
      rbyte = q_q.sticky;
    end
    if (ridx == IRQ_MASK_IDX) begin
      hit_r = 1'b1;
      rbyte = q_q.mask;
    end

    // write response once both halves are in
    if (wr_go) begin
      q_d.aw_have = 1'b0;
      q_d.w_have  = 1'b0;
      q_d.bvalid  = 1'b1;
      q_d.bresp   = hit_w ? RESP_OKAY : RESP_SLVERR;
    end
    if (q_q.bvalid && bready) begin
      q_d.bvalid  = 1'b0;
      q_d.awready = 1'b1;
      q_d.wready  = 1'b1;
    end

    // read answer one cycle after the address is taken
    if (rd_go) begin
      q_d.arready = 1'b0;
      q_d.rvalid  = 1'b1;
      q_d.rresp   = hit_r ? RESP_OKAY : RESP_SLVERR;
      q_d.rdata   = {24'h000000, hit_r ? rbyte : 8'h00};
    end
    if (q_q.rvalid && rready) begin
      q_d.rvalid  = 1'b0;
      q_d.arready = 1'b1;
    end

    // per-port receiver and transmitter
    for (int i = 0; i < NP; i++) begin
      rise[i] = q_q.sclk_s2[i] && !q_q.sclk_s3[i];
      fall[i] = !q_q.sclk_s2[i] && q_q.sclk_s3[i];

      // receiver samples on rising link clock edges
      rx_new = {q_q.rx_sh[i][6:0], q_q.sdi_s2[i]};
      if (rise[i]) begin
        q_d.rx_sh[i]  = rx_new;
        q_d.rx_cnt[i] = q_q.rx_cnt[i] + 4'h1;
        if (q_q.rx_cnt[i] == BYTE_BITS - 4'h1) begin
          ev_rx[i]      = 1'b1;
          q_d.rx_cnt[i] = 4'h0;
          q_d.rxbuf[i]  = rx_new;
        end
      end
      // new byte wins over a read in the same cycle
      q_d.rx_full[i] = (q_q.rx_full[i] && !ev_rd_data[i]) || ev_rx[i];
      q_d.ovr[i]     = (q_q.ovr[i] && !ev_rd_data[i]) ||
                       (ev_rx[i] && q_q.rx_full[i] && !ev_rd_data[i]);

      // transmitter finishes on its eighth rising edge
      ev_done[i] = q_q.busy[i] && rise[i] &&
                   q_q.tx_cnt[i] == BYTE_BITS - 4'h1;
      ev_load[i] = q_q.tx_full[i] && (!q_q.busy[i] || ev_done[i]);
      if (ev_load[i]) begin
        q_d.tx_sh[i]  = q_q.txbuf[i];
        q_d.sdo[i]    = q_q.txbuf[i][7];
        q_d.tx_cnt[i] = 4'h0;
        q_d.busy[i]   = 1'b1;
      end else if (ev_done[i]) begin
        q_d.busy[i]   = 1'b0;                     // buffer empty here
      end else if (q_q.busy[i]) begin
        if (rise[i]) begin
          q_d.tx_cnt[i] = q_q.tx_cnt[i] + 4'h1;
        end
        if (fall[i] && q_q.tx_cnt[i] != 4'h0) begin // keep reloaded msb
          q_d.tx_sh[i] = {q_q.tx_sh[i][6:0], 1'b0};
          q_d.sdo[i]   = q_q.tx_sh[i][6];
        end
      end
      if (ev_wr_data[i]) begin
        q_d.txbuf[i] = q_q.wbyte;
      end
      q_d.tx_full[i] = (q_q.tx_full[i] && !ev_load[i]) ||
                       ev_wr_data[i];
      // taking a byte wins over a clear in the same cycle
      q_d.tx_irq[i]  = (q_q.tx_irq[i] && !ev_wr_data[i] &&
                        !ev_wr_stat[i]) || ev_load[i];
    end

    // sticky events: rx bytes low nibble, tx takes high nibble
    q_d.sticky = q_q.sticky;
    if (rd_go && ridx == IRQ_STAT_IDX) begin
      q_d.sticky = '0;
    end
    q_d.sticky = q_d.sticky | {ev_load, ev_rx};
    q_d.irq    = |(q_d.sticky & q_d.mask);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_q         <= '0;
      q_q.awready <= 1'b1;
      q_q.wready  <= 1'b1;
      q_q.arready <= 1'b1;
      q_q.mask    <= MASK_RST;
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  // outputs straight from the state register
  assign awready = q_q.awready;
  assign wready  = q_q.wready;
  assign bvalid  = q_q.bvalid;
  assign bresp   = q_q.bresp;
  assign arready = q_q.arready;
  assign rvalid  = q_q.rvalid;
  assign rresp   = q_q.rresp;
  assign rdata   = q_q.rdata;
  assign sdo     = q_q.sdo;
  assign rx_irq  = q_q.rx_full;
  assign tx_irq  = q_q.tx_irq;
  assign irq     = q_q.irq;

  // checks per port
  for (genvar g = 0; g < NP; g++) begin : g_chk
    a_rx_full: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_rx[g] |=> rx_irq[g] && stat[g][RX_FULL_BIT])
      else $error("receive byte did not raise full");
    a_rx_drop: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_rd_data[g] && !ev_rx[g] |=> !rx_irq[g])
      else $error("receive request stayed after read");
    a_zero_bits: assert property (@(posedge ref_clk) disable iff (rst)
      stat[g][6] == 1'b0 && stat[g][4] == 1'b0)
      else $error("bits 6 or 4 not zero");
    a_ovr_set: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_rx[g] && rx_irq[g] && !ev_rd_data[g] |=> stat[g][OVR_BIT])
      else $error("overrun not flagged");
    a_txfull_set: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_wr_data[g] |=> stat[g][TX_FULL_BIT] ##1 1'b1)
      else $error("transmit buffer write not shown");
    a_tx_take: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_load[g] |=> tx_irq[g] && $rose(stat[g][BUSY_BIT]) ||
      tx_irq[g] && $past(stat[g][BUSY_BIT]))
      else $error("transmit take did not request");
    a_tx_clear: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_wr_data[g] && !ev_load[g] |=> !tx_irq[g])
      else $error("data write left transmit request");
    a_stat_write: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_wr_stat[g] && !ev_load[g] && !ev_rx[g] |=>
      !tx_irq[g] && $stable(stat[g][RX_FULL_BIT]))
      else $error("status write misbehaved");
    a_low_bits: assert property (@(posedge ref_clk) disable iff (rst)
      stat[g][1:0] == 2'h0)
      else $error("bits 1:0 not zero");
    a_busy_hold: assert property (@(posedge ref_clk) disable iff (rst)
      ce && ev_done[g] && stat[g][TX_FULL_BIT] |=> stat[g][BUSY_BIT] [*2])
      else $error("busy dropped between bytes");
  end

endmodule // cssf_serial_status
`default_nettype wire

/* cssf_link_partner.sv */
`default_nettype none
module cssf_link_partner (
  output var logic [3:0] sclk,  // link clock per port, idle low
  output var logic [3:0] sdi,   // data towards the device
  input  wire logic [3:0] sdo   // data from the device
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [4];          // last byte shifted in per port
  initial begin
    sclk = 4'h0;
    sdi  = 4'h0;
  end
  // one frame of 8 bits msb first; the clock stands still outside it
  task automatic xfer(input int p, input logic [7:0] tx, input int half);
    for (int i = 7; i >= 0; i--) begin
      sdi[p] = tx[i];
      #(half);
      sclk[p] = 1'b1;
      got[p] = {got[p][6:0], sdo[p]};
      #(half);
      sclk[p] = 1'b0;
    end
    #(half);
    sdi[p] = ~tx[0];            // released line never shows a stale bit
  endtask
endmodule // cssf_link_partner
`default_nettype wire

/* clocked_serial_status_flags_tb.sv */
`default_nettype none
module clocked_serial_status_flags_tb
  import cssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              ref_clk, rst, ce;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_v;
  logic [3:0]        wstrb, sclk, sdi, sdo, rx_irq, tx_irq;
  logic [1:0]        bresp, rresp, rd_r, wr_r;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, irq;
  logic [7:0]        b0, b1;
  int                error_cnt, checks, cyc, seed;

  cssf_serial_status dut (.ref_clk, .rst, .ce, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sclk, .sdi, .sdo, .rx_irq, .tx_irq, .irq);
  cssf_link_partner u_lp (.sclk, .sdi, .sdo);

  // clock and hang limit
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // expected status byte
  function automatic logic [7:0] stat(input logic rx, ov, tf, bz);
    stat = 8'h00;
    stat[RX_FULL_BIT] = rx;
    stat[OVR_BIT] = ov;
    stat[TX_FULL_BIT] = tf;
    stat[BUSY_BIT] = bz;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // axi4-lite write: offer both channels, drop each when taken
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic a, w, b;
    @(posedge ref_clk);
    awaddr <= {ix, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      wr_r = bresp;
      @(posedge ref_clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
    // let the edge's updates settle before the caller looks at outputs
    @(negedge ref_clk);
  endtask

  // axi4-lite read into rd_v and rd_r
  task automatic rd(input logic [7:0] ix);
    logic a, r;
    @(posedge ref_clk);
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      a = arvalid & arready;
      r = rvalid;
      rd_v = rdata;
      rd_r = rresp;
      @(posedge ref_clk);
      if (a) arvalid <= 1'b0;
    end while (!r);
    rready <= 1'b0;
  endtask

  task automatic rdk(input logic [7:0] ix, input logic [7:0] exp);
    rd(ix);
    chk(rd_v, {24'h000000, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    seed = 92626;
    {rst, ce, wstrb} = {1'b1, 1'b1, 4'hF};
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) rdk(STAT_IDX[p], 8'h00);
    rd(8'h7F);
    chk({30'h0, rd_r}, {30'h0, RESP_SLVERR});
    wr(8'h7F, 8'h00);
    chk({30'h0, wr_r}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    wr(IRQ_MASK_IDX, 8'hFF);
    chk({30'h0, wr_r}, {30'h0, RESP_OKAY});
    for (int p = 0; p < 4; p++) begin
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      // receive, unmasked event, then overrun
      u_lp.xfer(p, b0, 100);
      rdk(STAT_IDX[p], stat(1, 0, 0, 0));
      chk({31'h0, rx_irq[p]}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdk(IRQ_STAT_IDX, 8'(1 << p));
      chk({31'h0, irq}, 32'h0);
      u_lp.xfer(p, b1, 100);
      rdk(STAT_IDX[p], stat(1, 1, 0, 0));
      rdk(DATA_IDX[p], b1);
      rdk(STAT_IDX[p], 8'h00);
      chk({31'h0, rx_irq[p]}, 32'h0);
      // two bytes back to back
      wr(DATA_IDX[p], b0);
      chk({31'h0, tx_irq[p]}, 32'h1);
      rdk(STAT_IDX[p], stat(0, 0, 0, 1));
      wr(DATA_IDX[p], b1);
      chk({31'h0, tx_irq[p]}, 32'h0);
      rdk(STAT_IDX[p], stat(0, 0, 1, 1));
      u_lp.xfer(p, ~b0, 100);
      chk({24'h000000, u_lp.got[p]}, {24'h000000, b0});
      rdk(STAT_IDX[p], stat(1, 0, 0, 1));
      chk({31'h0, tx_irq[p]}, 32'h1);
      wr(STAT_IDX[p], 8'hFF);
      chk({31'h0, tx_irq[p]}, 32'h0);
      rdk(STAT_IDX[p], stat(1, 0, 0, 1));
      u_lp.xfer(p, b1, 100);
      chk({24'h000000, u_lp.got[p]}, {24'h000000, b1});
      rdk(STAT_IDX[p], stat(1, 1, 0, 0));
      rdk(DATA_IDX[p], b1);
      rdk(IRQ_STAT_IDX, 8'((1 << p) | (1 << (4 + p))));
      $display("test port %0d done", p);
    end
    // masked events leave the summary low
    wr(IRQ_MASK_IDX, 8'h00);
    rdk(IRQ_MASK_IDX, MASK_RST);
    // a mask write without the low lane strobe stores nothing
    wstrb <= 4'h0;
    wr(IRQ_MASK_IDX, 8'hFF);
    rdk(IRQ_MASK_IDX, 8'h00);
    wstrb <= 4'hF;
    u_lp.xfer(0, 8'h5A, 100);
    chk({31'h0, irq}, 32'h0);
    rdk(DATA_IDX[0], 8'h5A);
    $display("test mask done");
    complete_run();
  end
endmodule // clocked_serial_status_flags_tb
`default_nettype wire
